// File: src/ext_area_wait_ctrl.sv
/*
 * external area wait controller: apb register file, area decode and the
 * bus cycle sequencer that adds wait states per area and wait mode.
 * assumes the cpu side holds its request until the done pulse and drops it
 * then; the wait pin is asynchronous to pclk.
 */
// Added by the designer: the APB register port and the address map.
// How it works
// [R1] external space splits into eight areas of 128 kbytes or 2 Mbytes by address mode.
// [R2] an area with its access-state bit clear runs two states and never waits.
// [R3] an area with its access-state bit set runs three states plus any waits.
// [R4] wait enable 0 picks pin wait mode zero, else the global mode bits pick the mode.
// [R5] access-state and wait-enable bits are per area, the wait mode is shared.
// [R6] pin wait mode zero waits while the wait pin is low at the second state.
// [R7] pin wait mode one inserts the count, then waits on while the pin stays low.
// [R8] pin wait mode one with count zero behaves as pin wait mode zero.
// [R9] auto-wait inserts exactly the count when the pin is low at the second state.
// [R10] programmable mode inserts exactly the count and ignores the pin.
// [R11] reset sets access-state and wait-enable to all ones and wait config to F3.
// [R12] the external party holds the wait pin low for as long as it needs more states.
// [R13] the two-bit count gives zero, one, two or three wait states.
// [R14] new settings apply from the bus cycle after the write.
// [R15] the area is the three address bits above the area size boundary.
// [R16] on-chip accesses get no area timing or waits.
`default_nettype none

module ext_area_wait_ctrl (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic                           pready,
   output logic [31:0]                    prdata,
   output logic                           pslverr,
   input  wire ext_area_pkg::cyc_req_s    cyc_req,
   input  wire logic                      wait_n,
   output logic                           cyc_done,
   output logic [4:0]                     bus_phase,
   output logic [2:0]                     area_sel,
   output logic                           wait_inserting
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic [2:0] area_of(input logic [23:0] a, input logic m16);
      area_of = m16 ? a[ext_area_pkg::AREA_LSB_16M +: 3]          // [R1] [R15]
                    : a[ext_area_pkg::AREA_LSB_1M +: 3];
   endfunction

   // waits owed when the second state ends; pin extension comes later
   function automatic logic [2:0] first_waits(input ext_area_pkg::wait_mode_e m,
                                              input logic [1:0]               c,
                                              input logic                     low);
      first_waits = 3'h0;
      case (m)
         ext_area_pkg::WM_PROG: begin
            first_waits = {1'b0, c};                                 // [R10] [R13]
         end
         ext_area_pkg::WM_OFF: begin
            first_waits = 3'h0;                                      // [R4]
         end
         ext_area_pkg::WM_PIN1: begin
            if (c != 2'h0) begin
               first_waits = {1'b0, c};                              // [R7]
            end else begin
               first_waits = {2'h0, low};                            // [R8] [R6]
            end
         end
         ext_area_pkg::WM_AUTO: begin
            first_waits = low ? {1'b0, c} : 3'h0;                    // [R9]
         end
         default: begin
            first_waits = 3'h0;
         end
      endcase
   endfunction

   // ----------------------------------------
   // wait pin synchroniser
   // ----------------------------------------
   logic wsync1_q, wsync2_q, wsync3_q, wait_lvl_q, wait_lvl_d;
   always_comb begin
      wait_lvl_d = wait_lvl_q;
      if (wsync2_q == wsync3_q) begin
         wait_lvl_d = wsync3_q;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wsync1_q   <= 1'b1;
         wsync2_q   <= 1'b1;
         wsync3_q   <= 1'b1;
         wait_lvl_q <= 1'b1;
      end else begin
         wsync1_q   <= wait_n;
         wsync2_q   <= wsync1_q;
         wsync3_q   <= wsync2_q;
         wait_lvl_q <= wait_lvl_d;
      end
   end
   logic wait_low;
   assign wait_low = ~wait_lvl_q;   // [R12]

   // ----------------------------------------
   // apb register file
   // ----------------------------------------
   logic [7:0]  ast_q, ast_d, wce_q, wce_d, wcfg_q, wcfg_d;
   logic        m16_q, m16_d, pready_q, pready_d, pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic        wr_seen_q, wr_seen_d;
   // sequencer state; declared here because the status word reads it
   ext_area_pkg::bus_state_e state_q, state_d;
   ext_area_pkg::wait_mode_e mode_q, mode_d;
   logic [2:0]               area_q, area_d;
   logic [1:0]               cnt_q, cnt_d, fixw_q, fixw_d;
   logic                     three_q, three_d, pin_q, pin_d;
   logic                     cyc_done_q, cyc_done_d, winsert_q, winsert_d;
   always_comb begin
      logic wr_go;
      logic hit;
      wr_go     = 1'b0;
      hit       = 1'b1;
      ast_d     = ast_q;
      wce_d     = wce_q;
      wcfg_d    = wcfg_q;
      m16_d     = m16_q;
      wr_seen_d = wr_seen_q;
      prdata_d  = 32'h0000_0000;
      pready_d  = psel & penable & ~pready_q;
      pslverr_d = 1'b0;
      wr_go     = psel & penable & pready_q & pwrite;
      if (paddr == ext_area_pkg::OFF_ACCESS_STATE) begin
         prdata_d[7:0] = ast_q;
         if (wr_go) ast_d = pwdata[7:0];                           // [R5]
      end else if (paddr == ext_area_pkg::OFF_WAIT_ENABLE) begin
         prdata_d[7:0] = wce_q;
         if (wr_go) wce_d = pwdata[7:0];                           // [R5]
      end else if (paddr == ext_area_pkg::OFF_WAIT_CONFIG) begin
         prdata_d[7:0] = wcfg_q;
         if (wr_go) wcfg_d = {ext_area_pkg::WCFG_RSVD_ONES, pwdata[3:0]};
      end else if (paddr == ext_area_pkg::OFF_ADDR_MODE) begin
         prdata_d[0] = m16_q;
         if (wr_go) m16_d = pwdata[0];
      end else if (paddr == ext_area_pkg::OFF_STATUS) begin
         prdata_d[13:0] = {wr_seen_q, wait_lvl_q, area_q, state_q, cnt_q, pin_q, three_q};
      end else begin
         hit = 1'b0;
      end
      if (wr_go) wr_seen_d = 1'b1;
      if (!pready_d) prdata_d = 32'h0000_0000;
      pslverr_d = pready_d & ~hit;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ast_q     <= ext_area_pkg::RST_ACCESS_STATE;              // [R11]
         wce_q     <= ext_area_pkg::RST_WAIT_ENABLE;               // [R11]
         wcfg_q    <= ext_area_pkg::RST_WAIT_CONFIG;               // [R11]
         m16_q     <= ext_area_pkg::RST_ADDR_MODE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         wr_seen_q <= 1'b0;
      end else begin
         ast_q     <= ast_d;
         wce_q     <= wce_d;
         wcfg_q    <= wcfg_d;
         m16_q     <= m16_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
         wr_seen_q <= wr_seen_d;
      end
   end
   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------
   // bus cycle sequencer
   // ----------------------------------------
   // a three-state access holds its second state for four clocks so that the
   // synchronised wait level at its end shows the pin as it stood in t1;
   // trade-off: a longer cycle in exchange for a metastability-safe pin
   always_comb begin
      logic [2:0] owed;
      owed       = first_waits(mode_q, fixw_q, wait_low);
      state_d    = state_q;
      mode_d     = mode_q;
      area_d     = area_q;
      cnt_d      = cnt_q;
      fixw_d     = fixw_q;
      three_d    = three_q;
      pin_d      = pin_q;
      cyc_done_d = 1'b0;
      case (state_q)
         ext_area_pkg::ST_IDLE: begin
            if (cyc_req.valid && !cyc_done_q) begin
               if (cyc_req.on_chip) begin
                  cyc_done_d = 1'b1;                                 // [R16]
               end else begin
                  area_d  = area_of(cyc_req.addr, m16_q);            // [R1] [R15]
                  three_d = ast_q[area_d];                           // [R2] [R3] [R14]
                  if (!wce_q[area_d]) begin
                     mode_d = ext_area_pkg::WM_PIN1;                 // [R4] [R8]
                     fixw_d = 2'h0;
                  end else begin
                     mode_d = ext_area_pkg::wait_mode_e'({wcfg_q[ext_area_pkg::WAIT_MODE_SEL_HI_POS],
                                                           wcfg_q[ext_area_pkg::WAIT_MODE_SEL_LO_POS]});
                     fixw_d = {wcfg_q[ext_area_pkg::WAIT_COUNT_HI_POS],
                               wcfg_q[ext_area_pkg::WAIT_COUNT_LO_POS]};  // [R5] [R13]
                  end
                  pin_d   = (mode_d == ext_area_pkg::WM_PIN1);       // [R7]
                  cnt_d   = 2'h0;
                  state_d = ext_area_pkg::ST_T1;
               end
            end
         end
         ext_area_pkg::ST_T1: begin
            state_d = ext_area_pkg::ST_T2;
            cnt_d   = 2'h0;
            if (!three_q) begin
               cyc_done_d = 1'b1;                                    // [R2]
            end
         end
         ext_area_pkg::ST_T2: begin
            if (!three_q) begin
               state_d = ext_area_pkg::ST_IDLE;                      // [R2]
            end else if (cnt_q != ext_area_pkg::T2_LAST) begin
               cnt_d = cnt_q + 2'h1;                                 // [R6]
            end else if (owed == 3'h0) begin
               state_d    = ext_area_pkg::ST_T3;                     // [R3]
               cyc_done_d = 1'b1;
            end else begin
               state_d = ext_area_pkg::ST_TW;
               cnt_d   = owed[1:0] - 2'h1;
            end
         end
         ext_area_pkg::ST_TW: begin
            if (cnt_q != 2'h0) begin
               cnt_d = cnt_q - 2'h1;                                 // [R10] [R13]
            end else if (pin_q && wait_low) begin
               state_d = ext_area_pkg::ST_TW;                        // [R6] [R7]
            end else begin
               state_d    = ext_area_pkg::ST_T3;
               cyc_done_d = 1'b1;
            end
         end
         ext_area_pkg::ST_T3: begin
            state_d = ext_area_pkg::ST_IDLE;
         end
         default: begin
            state_d = ext_area_pkg::ST_IDLE;
         end
      endcase
      winsert_d = (state_d == ext_area_pkg::ST_TW);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ext_area_pkg::ST_IDLE;
         mode_q     <= ext_area_pkg::WM_PROG;
         area_q     <= 3'h0;
         cnt_q      <= 2'h0;
         fixw_q     <= 2'h0;
         three_q    <= 1'b0;
         pin_q      <= 1'b0;
         cyc_done_q <= 1'b0;
         winsert_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         mode_q     <= mode_d;
         area_q     <= area_d;
         cnt_q      <= cnt_d;
         fixw_q     <= fixw_d;
         three_q    <= three_d;
         pin_q      <= pin_d;
         cyc_done_q <= cyc_done_d;
         winsert_q  <= winsert_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign cyc_done       = cyc_done_q;
   assign bus_phase      = state_q;
   assign area_sel       = area_q;
   assign wait_inserting = winsert_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // the done guard in idle keeps a held request from starting twice
   sequence s_settle;
      (state_q == ext_area_pkg::ST_T2) [*4];
   endsequence

   sequence s_two_state;
      (state_q == ext_area_pkg::ST_T2) ##1 (state_q == ext_area_pkg::ST_IDLE);
   endsequence

   two_state_a: assert property (@(posedge pclk) disable iff (!presetn)   // [R2]
      ((state_q == ext_area_pkg::ST_T1) && !three_q) |=> s_two_state)
      else $error("two-state access did not end after its second state");

   no_wait_a: assert property (@(posedge pclk) disable iff (!presetn)     // [R2]
      !three_q |-> (state_q != ext_area_pkg::ST_TW))
      else $error("wait state in a two-state access");

   t2_settle_a: assert property (@(posedge pclk) disable iff (!presetn)   // [R3]
      ((state_q == ext_area_pkg::ST_T1) && three_q) |=> s_settle ##1 (state_q != ext_area_pkg::ST_T2))
      else $error("second state of a three-state access has the wrong length");

   off_mode_a: assert property (@(posedge pclk) disable iff (!presetn)    // [R4]
      (three_q && (mode_q == ext_area_pkg::WM_OFF)) |-> (state_q != ext_area_pkg::ST_TW))
      else $error("wait state inserted in no-wait mode");

   pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)    // [R6]
      ((state_q == ext_area_pkg::ST_TW) && (cnt_q == 2'h0) && pin_q && wait_low)
      |=> (state_q == ext_area_pkg::ST_TW))
      else $error("pin wait ended while the pin was low");

   auto_end_a: assert property (@(posedge pclk) disable iff (!presetn)    // [R9]
      ((mode_q == ext_area_pkg::WM_AUTO) && (state_q == ext_area_pkg::ST_TW) && (cnt_q == 2'h0))
      |=> (state_q == ext_area_pkg::ST_T3))
      else $error("auto-wait inserted more than the count");

   prog_end_a: assert property (@(posedge pclk) disable iff (!presetn)    // [R10]
      ((mode_q == ext_area_pkg::WM_PROG) && (state_q == ext_area_pkg::ST_TW) && (cnt_q == 2'h0))
      |=> (state_q == ext_area_pkg::ST_T3))
      else $error("programmable wait inserted more than the count");

   onchip_a: assert property (@(posedge pclk) disable iff (!presetn)      // [R16]
      ((state_q == ext_area_pkg::ST_IDLE) && cyc_req.valid && cyc_req.on_chip && !cyc_done_q)
      |=> ((state_q == ext_area_pkg::ST_IDLE) && cyc_done_q))
      else $error("on-chip access got external timing");
endmodule
`default_nettype wire

// File: src/ext_area_pkg.sv
/*
 * shared constants, modes, states and carriers of the external area
 * wait controller.
 * assumes one 200 MHz clock (pclk) and an apb master on the register side.
 */
`default_nettype none

package ext_area_pkg;

   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int AREA_N       = 8;
   localparam int ADDR_W       = 24;
   localparam int AREA_KB_1M   = 128;   // area size, 1-Mbyte address mode
   localparam int AREA_MB_16M  = 2;     // area size, 16-Mbyte address mode
   localparam int AREA_LSB_1M  = 17;    // log2 of 128 kbytes
   localparam int AREA_LSB_16M = 21;    // log2 of 2 Mbytes

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] OFF_ACCESS_STATE = 12'h000;
   localparam logic [11:0] OFF_WAIT_ENABLE  = 12'h004;
   localparam logic [11:0] OFF_WAIT_CONFIG  = 12'h008;
   localparam logic [11:0] OFF_ADDR_MODE    = 12'h00C;
   localparam logic [11:0] OFF_STATUS       = 12'h010;

   // ----------------------------------------
   // reset values and field positions
   // ----------------------------------------
   localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
   localparam logic [7:0] RST_WAIT_ENABLE  = 8'hFF;
   localparam logic [7:0] RST_WAIT_CONFIG  = 8'hF3;
   localparam logic       RST_ADDR_MODE    = 1'b0;
   localparam logic [3:0] WCFG_RSVD_ONES   = 4'hF;
   localparam int WAIT_MODE_SEL_HI_POS = 3;
   localparam int WAIT_MODE_SEL_LO_POS = 2;
   localparam int WAIT_COUNT_HI_POS    = 1;
   localparam int WAIT_COUNT_LO_POS    = 0;

   // ----------------------------------------
   // wait modes and bus cycle states
   // ----------------------------------------
   // last clock of the stretched second state
   localparam logic [1:0] T2_LAST = 2'h3;

   typedef enum logic [1:0] {
      WM_PROG = 2'h0,
      WM_OFF  = 2'h1,
      WM_PIN1 = 2'h2,
      WM_AUTO = 2'h3
   } wait_mode_e;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_T1   = 5'h02,
      ST_T2   = 5'h04,
      ST_TW   = 5'h08,
      ST_T3   = 5'h10
   } bus_state_e;

   typedef struct packed {
      logic              valid;
      logic              on_chip;
      logic [ADDR_W-1:0] addr;
   } cyc_req_s;

endpackage

`default_nettype wire

// File: dv/wait_partner.sv
/* partner: external 8-bit device that stretches cycles on wait_n.
   assumes bus_phase carries the one-hot sequencer state. */
`default_nettype none
module wait_partner (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [4:0] bus_phase,
   input  wire logic [1:0] hold,
   output logic            wait_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       in_cyc;
   logic [2:0] cnt_q;
   assign in_cyc = (bus_phase == ext_area_pkg::ST_T1) || (bus_phase == ext_area_pkg::ST_T2) ||
                   (bus_phase == ext_area_pkg::ST_TW);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 3'h0;
      else cnt_q <= in_cyc ? cnt_q + 3'h1 : 3'h0;
   end
   // low from the first state, ahead of the pin synchroniser, until hold is used; high outside
   assign wait_n = !(in_cyc && ({1'b0, hold} > cnt_q));
endmodule
`default_nettype wire

// File: dv/testbench.sv
/* bench: apb setup and external cycles against the wait partner.
   assumes cyc_done pulses once per held request. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic                   cyc_done, wait_n, wins;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic [4:0]             bus_phase;
   logic [2:0]             area_sel, ar;
   logic [1:0]             hold;
   ext_area_pkg::cyc_req_s cyc_req;
   int                     mismatches, cmp_count, nw, n3, nwi;
   ext_area_wait_ctrl i_ext_area_wait_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cyc_req(cyc_req), .wait_n(wait_n),
      .cyc_done(cyc_done), .bus_phase(bus_phase), .area_sel(area_sel), .wait_inserting(wins));
   wait_partner i_wait_partner (.pclk(pclk), .presetn(presetn), .bus_phase(bus_phase),
      .hold(hold), .wait_n(wait_n));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input bit ok);
      cmp_count++;
      if (!ok) begin
         mismatches++;
         $display("unexpected at %0t: observed value differs", $time);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // waits counted per sampled state, so no latency is assumed
   task automatic cyc(input logic oc, input logic [23:0] a, input logic [1:0] h);
      @(posedge pclk);
      hold <= h;
      cyc_req <= '{valid: 1'b1, on_chip: oc, addr: a};
      nw = 0;
      n3 = 0;
      nwi = 0;
      do begin
         @(posedge pclk);
         nw += int'(bus_phase === ext_area_pkg::ST_TW);
         n3 += int'(bus_phase === ext_area_pkg::ST_T3);
         nwi += int'(wins === 1'b1);
         if (bus_phase === ext_area_pkg::ST_T2) ar = area_sel;
      end while (cyc_done !== 1'b1);
      cyc_req <= '0;
   endtask
   function automatic int exp_w(input int m, input int c, input int h);
      case (m)
         0: return c;
         1: return 0;
         2: return (h > c) ? h : c;
         default: return (h > 0) ? c : 0;
      endcase
   endfunction
   task automatic t_reset;
      apb(1'b0, ext_area_pkg::OFF_ACCESS_STATE, 32'h0);
      chk(rd[7:0] === 8'hFF);
      apb(1'b0, ext_area_pkg::OFF_WAIT_ENABLE, 32'h0);
      chk(rd[7:0] === 8'hFF);
      apb(1'b0, ext_area_pkg::OFF_WAIT_CONFIG, 32'h0);
      chk(rd[7:0] === 8'hF3);
      cyc(1'b0, 24'h000100, 2'h0);
      chk(nw == 3 && n3 == 1);
      apb(1'b0, 12'h040, 32'h0);
      chk(err === 1'b1);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++) for (int c = 0; c < 4; c++) begin
         apb(1'b1, ext_area_pkg::OFF_WAIT_CONFIG, {28'h000000F, m[1:0], c[1:0]});
         cyc(1'b0, 24'h000100, 2'h2);
         chk(nw == exp_w(m, c, 2) && n3 == 1 && nwi == exp_w(m, c, 2));
      end
   endtask
   task automatic t_areas;
      apb(1'b1, ext_area_pkg::OFF_WAIT_CONFIG, 32'h000000F1);
      apb(1'b1, ext_area_pkg::OFF_WAIT_ENABLE, 32'h000000FE);
      cyc(1'b0, 24'h000100, 2'h3);
      chk(nw == 3);
      cyc(1'b0, 24'h020000, 2'h3);
      chk(nw == 1 && ar === 3'h1);
      apb(1'b1, ext_area_pkg::OFF_ACCESS_STATE, 32'h000000FB);
      cyc(1'b0, 24'h040000, 2'h3);
      chk(nw == 0 && n3 == 0);
      cyc(1'b0, 24'h060000, 2'h0);
      chk(nw == 1 && n3 == 1);
      cyc(1'b0, 24'h0A0000, 2'h0);
      chk(ar === 3'h5);
      apb(1'b1, ext_area_pkg::OFF_ADDR_MODE, 32'h00000001);
      cyc(1'b0, 24'hA00000, 2'h0);
      chk(ar === 3'h5);
      cyc(1'b1, 24'h000100, 2'h3);
      chk(nw == 0);
   endtask
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, hold} = '0;
      cyc_req = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_modes();
      t_areas();
      stop_test();
   end
endmodule
`default_nettype wire
